// File: wwrs_pkg.sv
package wwrs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and timing resistor

   // clock period in picoseconds (125 MHz)
   localparam longint CLK_PERIOD_PS = 64'd8000;
   // default timing resistor value in ohms
   localparam longint TIMING_OHM = 64'd60000;
   // picoseconds per unit of the coefficients below (1e-10 s)
   localparam longint COEF_UNIT_PS = 64'd100;

   // coefficients in units of 1e-10 seconds per ohm
   localparam longint WAKE_PERIOD_COEF = 64'd4170; // 4.17e-7 s/ohm
   localparam longint RST_DELAY_COEF = 64'd521;    // 5.21e-8 s/ohm
   localparam longint WAKE_DELAY_COEF = 64'd2080;  // 2.08e-7 s/ohm

   ////////////////////////////////////////////////////////////////////////
   // derived cycle counts, least times rounded up

   // width of every time-base counter
   localparam int CNT_W = 24;

   localparam longint WAKE_PERIOD_PS =
      TIMING_OHM * WAKE_PERIOD_COEF * COEF_UNIT_PS;
   localparam longint RST_DELAY_PS =
      TIMING_OHM * RST_DELAY_COEF * COEF_UNIT_PS;
   localparam longint WAKE_DELAY_PS =
      TIMING_OHM * WAKE_DELAY_COEF * COEF_UNIT_PS;

   localparam logic [23:0] WAKE_PERIOD_CYC =
      24'((WAKE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [23:0] RST_DELAY_CYC =
      24'((RST_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [23:0] WAKE_DELAY_CYC =
      24'((WAKE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // typical watchdog-to-wakeup response, longest time rounded down
   localparam longint WAKE_RESP_NS = 64'd2000;
   localparam logic [23:0] WAKE_RESP_CYC =
      24'(WAKE_RESP_NS * 64'd1000 / CLK_PERIOD_PS);
   // least watchdog phase width the processor keeps, rounded up
   localparam longint WDOG_PHASE_NS = 64'd5000;
   localparam logic [23:0] WDOG_PHASE_CYC =
      24'((WDOG_PHASE_NS * 64'd1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   ////////////////////////////////////////////////////////////////////////
   // states and output carrier

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,       // output not good, reset held low
      ST_RST_DELAY = 2'b01,  // reset low, counting reset delay
      ST_WAKE_DELAY = 2'b10, // reset high, waiting for first wakeup
      ST_RUN = 2'b11         // wakeup cycles running
   } wwrs_state_t;

   typedef struct packed {
      logic reset_out_n; // active-low reset toward the processor
      logic wakeup;      // wakeup square wave toward the processor
   } wwrs_pins_t;

endpackage

// File: wwrs_counter.sv
`timescale 1ns/1ps

// free-running up counter with synchronous clear and terminal flag
module wwrs_counter #(
   parameter int W = 24
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clear,
   input wire logic [W-1:0] limit,
   // status
   output logic [W-1:0] count,
   output logic done
);

   // count register
   logic [W-1:0] count_reg;

   ////////////////////////////////////////////////////////////////////////
   // counting; clear has priority so a restart never skips a tick
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         count_reg <= '0;
      else if (clear)
         count_reg <= '0;
      else
         count_reg <= count_reg + W'(1);
   end

   assign count = count_reg;
   // terminal tick: last cycle of a span of limit cycles
   assign done = (count_reg == limit - W'(1));

endmodule // wwrs_counter

// File: wwrs_top.sv
`timescale 1ns/1ps

module wwrs_top #(
   parameter logic [23:0] WAKE_PERIOD_CYC = wwrs_pkg::WAKE_PERIOD_CYC,
   parameter logic [23:0] RST_DELAY_CYC = wwrs_pkg::RST_DELAY_CYC,
   parameter logic [23:0] WAKE_DELAY_CYC = wwrs_pkg::WAKE_DELAY_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // supervised condition from the regulator
   input wire logic out_good,
   // processor watchdog line
   input wire logic watchdog_input,
   // outputs toward the processor
   output wwrs_pkg::wwrs_pins_t pins
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   // half period, the high phase of the wakeup wave
   localparam logic [23:0] HALF_CYC = WAKE_PERIOD_CYC >> 1;

   wwrs_pkg::wwrs_state_t state_reg; // supervisor state
   wwrs_pkg::wwrs_state_t state_next; // its next value
   logic wdog_meta_reg; // first synchroniser stage, read by stage two only
   logic wdog_sync_reg; // second synchroniser stage
   logic wdog_prev_reg; // previous synchronised sample
   logic wdog_fall; // falling edge seen this tick
   logic seen_reg; // an edge has already been taken in this cycle
   logic wake_reg; // wakeup pin driver
   logic rstn_reg; // reset pin driver
   logic [23:0] dly_limit; // length of the current delay state
   logic dly_clear; // restart the delay counter
   logic dly_done; // last tick of the delay
   logic per_clear; // restart the period counter
   logic per_done; // last tick of a wakeup cycle
   logic [23:0] per_count; // position inside the wakeup cycle
   logic missed; // a cycle ended without any edge

   ////////////////////////////////////////////////////////////////////////
   // watchdog synchroniser and edge detector

   // two flops bring the pin into the clock domain
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wdog_meta_reg <= 1'b1;
         wdog_sync_reg <= 1'b1;
      end
      else
      begin
         wdog_meta_reg <= watchdog_input;
         wdog_sync_reg <= wdog_meta_reg;
      end
   end

   // third flop keeps the last sample for edge detection
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         wdog_prev_reg <= 1'b1;
      else
         wdog_prev_reg <= wdog_sync_reg;
   end

   // rising edges are deliberately not decoded
   assign wdog_fall = wdog_prev_reg & ~wdog_sync_reg;

   ////////////////////////////////////////////////////////////////////////
   // time-base counters

   // delay counter serves both reset delay and wake delay
   wwrs_counter #(
      .W(wwrs_pkg::CNT_W)
   ) u_dly (
      .clk(clk),
      .rst_n(rst_n),
      .clear(dly_clear),
      .limit(dly_limit),
      .count(),
      .done(dly_done)
   );

   // period counter paces the wakeup wave
   wwrs_counter #(
      .W(wwrs_pkg::CNT_W)
   ) u_per (
      .clk(clk),
      .rst_n(rst_n),
      .clear(per_clear),
      .limit(WAKE_PERIOD_CYC),
      .count(per_count),
      .done(per_done)
   );

   // pick the span of whichever delay state is active
   always_comb
   begin
      if (state_reg == wwrs_pkg::ST_RST_DELAY)
         dly_limit = RST_DELAY_CYC;
      else
         dly_limit = WAKE_DELAY_CYC;
   end

   // delay restarts on every state change and idles outside delays
   assign dly_clear = (state_next != state_reg) ||
                      (state_reg == wwrs_pkg::ST_HOLD) ||
                      (state_reg == wwrs_pkg::ST_RUN);

   // period restarts each cycle end and whenever not running
   assign per_clear = (state_reg != wwrs_pkg::ST_RUN) || per_done;

   // an edge on the very last tick still counts for the ending cycle
   assign missed = per_done && !seen_reg && !wdog_fall;

   ////////////////////////////////////////////////////////////////////////
   // supervisor state machine

   // next state; loss of output good overrides everything
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         wwrs_pkg::ST_HOLD:
         begin
            // stay low from power-up until regulation is reached
            if (out_good)
               state_next = wwrs_pkg::ST_RST_DELAY;
         end
         wwrs_pkg::ST_RST_DELAY:
         begin
            if (!out_good)
               state_next = wwrs_pkg::ST_HOLD;
            else if (dly_done)
               state_next = wwrs_pkg::ST_WAKE_DELAY;
         end
         wwrs_pkg::ST_WAKE_DELAY:
         begin
            if (!out_good)
               state_next = wwrs_pkg::ST_HOLD;
            else if (dly_done)
               state_next = wwrs_pkg::ST_RUN;
         end
         wwrs_pkg::ST_RUN:
         begin
            if (!out_good)
               state_next = wwrs_pkg::ST_HOLD;
            else if (missed)
               state_next = wwrs_pkg::ST_RST_DELAY;
         end
         default:
         begin
            // unreachable code points fall back to a safe hold
            state_next = wwrs_pkg::ST_HOLD;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state_reg <= wwrs_pkg::ST_HOLD;
      else
         state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // per-cycle edge memory

   // one edge per cycle is acted on, the rest fall on a set flag
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         seen_reg <= 1'b0;
      else if (state_reg != wwrs_pkg::ST_RUN || per_done)
         seen_reg <= 1'b0; // new cycle starts with a clean slate
      else if (wdog_fall)
         seen_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // output drivers

   // wakeup: high for the first half of each cycle, cut short by an edge
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         wake_reg <= 1'b0;
      else if (state_reg != wwrs_pkg::ST_RUN || !out_good)
         wake_reg <= 1'b0; // falls with the reset pin on a loss
      else if (wdog_fall || seen_reg)
         wake_reg <= 1'b0;
      else
         wake_reg <= (per_count < HALF_CYC);
   end

   // reset pin is high only once the reset delay has been reached
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rstn_reg <= 1'b0;
      else
         // out_good gates the pin directly, so a loss that lands on the
         // delay-to-wake step cannot let a one-tick high pulse slip out
         rstn_reg <= out_good &&
                     ((state_reg == wwrs_pkg::ST_WAKE_DELAY) ||
                      (state_reg == wwrs_pkg::ST_RUN));
   end

   // both pins come straight from flops, no glitches toward the cpu
   assign pins.reset_out_n = rstn_reg;
   assign pins.wakeup = wake_reg;

endmodule // wwrs_top

// File: wwrs_monitor.sv
`timescale 1ns/1ps

// watches the supervisor pins against their causes at the inputs
module wwrs_monitor #(
   parameter int P = 4000,
   parameter int RD = 20,
   parameter int WD = 50
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched signals
   input wire logic out_good,
   input wire logic watchdog_input,
   input wire wwrs_pkg::wwrs_pins_t pins
);
   localparam int H = P / 2; // high phase of the wakeup wave
   localparam int WD1 = WD - 1; // delay inside the quiet wait, one less than its WD low ticks
   logic [23:0] cnt; // ticks since the last wakeup rise
   logic [23:0] low_cnt; // ticks that reset has been low
   logic run_ok; // a wakeup rise seen since the last reset
   logic wd_seen; // watchdog fell in the current cycle

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   // helpers, cleared in reset so no stale history reaches a check
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt <= 24'h0;
         low_cnt <= 24'h0;
         run_ok <= 1'b0;
         wd_seen <= 1'b0;
      end
      else
      begin
         cnt <= $rose(pins.wakeup) ? 24'h1 : cnt + 24'h1;
         low_cnt <= pins.reset_out_n ? 24'h0 : low_cnt + 24'h1;
         run_ok <= $rose(pins.wakeup) | (run_ok & pins.reset_out_n);
         wd_seen <= !$rose(pins.wakeup) & ($fell(watchdog_input) | wd_seen);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // release steps: quiet wait, then the first wakeup rise
   sequence s_quiet;
      !pins.wakeup throughout (##WD1 1'b1);
   endsequence
   sequence s_up;
      $rose(pins.wakeup) || !pins.reset_out_n;
   endsequence

   a_wake_in_reset: assert property (!pins.reset_out_n |-> !pins.wakeup)
      else $error("wakeup high while reset low");
   a_loss_resets: assert property (!out_good |-> ##2 !pins.reset_out_n)
      else $error("reset missing after output loss");
   a_hold_while_bad: assert property
      (!pins.reset_out_n && !out_good |=> !pins.reset_out_n)
      else $error("reset released while output bad");
   a_release_delay: assert property
      ($rose(pins.reset_out_n) |-> low_cnt >= RD && $past(out_good))
      else $error("reset released early");
   a_wake_delay: assert property
      ($rose(pins.reset_out_n) |-> s_quiet ##1 s_up)
      else $error("wakeup delay wrong");
   a_wdog_response: assert property
      ($fell(watchdog_input) && pins.wakeup |-> ##[1:5] !pins.wakeup)
      else $error("wakeup not lowered by watchdog");
   a_period_len: assert property ($rose(pins.wakeup) && run_ok |-> cnt == P)
      else $error("wakeup period wrong");
   a_half_duty: assert property
      ($fell(pins.wakeup) && pins.reset_out_n && !wd_seen |-> cnt == H)
      else $error("wakeup high phase wrong");
   a_miss_reset: assert property
      (run_ok && cnt == P && !wd_seen |-> ##[0:2] !pins.reset_out_n)
      else $error("no reset after silent cycle");
   a_kept_running: assert property
      (run_ok && cnt == P && wd_seen && pins.reset_out_n |-> $rose(pins.wakeup))
      else $error("cycle with watchdog not renewed");
endmodule // wwrs_monitor

bind wwrs_top wwrs_monitor #(.P(WAKE_PERIOD_CYC), .RD(RST_DELAY_CYC),
   .WD(WAKE_DELAY_CYC)) wwrs_monitor_inst (.clk(clk), .rst_n(rst_n),
   .out_good(out_good), .watchdog_input(watchdog_input), .pins(pins));

// File: wwrs_host_model.sv
`timescale 1ns/1ps

// sleeping host: answers each wakeup rise with one, two or no watchdog pulses, as set by mode
module wwrs_host_model (
   // clock
   input wire logic clk,
   // wakeup and controls: mode 0 one pulse, 1 silent, 2 two pulses
   input wire logic wakeup,
   input wire logic [1:0] mode,
   input wire logic [8:0] dly,
   // watchdog line, idle high
   output logic watchdog_input
);
   localparam int PH = 625; // 5 us phase at 8 ns a tick

   // mode is read only after the delay, so it may change just after a rise
   initial
   begin
      watchdog_input = 1'b1;
      forever
      begin
         @(posedge wakeup);
         repeat (dly) @(negedge clk);
         repeat (mode == 2'h0 ? 1 : (mode == 2'h2 ? 2 : 0))
         begin
            watchdog_input = 1'b0;
            repeat (PH) @(negedge clk);
            watchdog_input = 1'b1;
            repeat (PH) @(negedge clk);
         end
      end
   end
endmodule // wwrs_host_model

// File: testbench.sv
`timescale 1ns/1ps

// power-up, watchdog answers, a silent cycle, output loss, second reset
module testbench;
   localparam int P = 4000; // shortened wakeup period
   localparam int H = P / 2;
   localparam int RD = 20; // shortened reset delay
   localparam int WD = 50; // shortened reset-high-to-wakeup delay
   typedef struct {logic [1:0] v; int gap;} wwrs_note_t; // gap 0: any
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic out_good = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [8:0] dly = 9'h2;
   logic watchdog_input;
   wwrs_pkg::wwrs_pins_t pins;
   wwrs_note_t notes[$]; // expected pin changes, oldest first
   wwrs_note_t n;
   logic [1:0] last = 2'h0;
   logic [1:0] seq [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h0};
   int cyc = 0;
   int last_cyc = 0;
   int error_cnt = 0;
   int num_checks = 0;

   initial forever #4 clk = ~clk;

   wwrs_top #(.WAKE_PERIOD_CYC(24'(P)), .RST_DELAY_CYC(24'(RD)),
      .WAKE_DELAY_CYC(24'(WD))) wwrs_top_inst (.clk(clk), .rst_n(rst_n),
      .out_good(out_good), .watchdog_input(watchdog_input), .pins(pins));
   wwrs_host_model wwrs_host_model_inst (.clk(clk), .wakeup(pins.wakeup),
      .mode(mode), .dly(dly), .watchdog_input(watchdog_input));

   task check(string what, logic [23:0] seen, logic [23:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // bounded wait for the next wakeup rise, seen at a falling edge
   task automatic to_rise();
      int k;
      k = 0;
      for (; k < 3 * P && pins.wakeup !== 1'b0; k++) @(negedge clk);
      for (; k < 3 * P && pins.wakeup !== 1'b1; k++) @(negedge clk);
      if (k >= 3 * P)
         error_cnt++;
   endtask

   // one wakeup cycle with the host in mode m
   task automatic cycle(logic [1:0] m);
      mode = m;
      dly = 9'($urandom_range(2, 400));
      notes.push_back('{2'h2, m == 2'h1 ? H : 0});
      if (m == 2'h1)
      begin
         notes.push_back('{2'h0, 0});
         notes.push_back('{2'h2, RD});
      end
      notes.push_back('{2'h3, m == 2'h1 ? WD : 0});
      to_rise();
   endtask

   // scoreboard: every pin change takes the oldest note
   always @(negedge clk)
   begin
      cyc++;
      if (pins !== last)
      begin
         n = notes.size() ? notes.pop_front() : wwrs_note_t'{2'hx, 0};
         check("pins", 24'(pins), 24'(n.v));
         if (n.gap != 0)
            check("gap", 24'(cyc - last_cyc), 24'(n.gap));
         last = pins;
         last_cyc = cyc;
      end
   end

   initial
   begin
      #600000;
      error_cnt++;
      conclude();
   end

   // main sequence, inputs move on falling edges only
   initial
   begin
      void'($urandom(32'h583DBE7D));
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (30) @(negedge clk);
      notes.push_back('{2'h2, 0});
      notes.push_back('{2'h3, WD});
      out_good = 1'b1;
      to_rise();
      foreach (seq[i]) cycle(seq[i]);
      mode = 2'h1;
      repeat (100) @(negedge clk);
      notes.push_back('{2'h0, 0});
      out_good = 1'b0;
      repeat ($urandom_range(20, 100)) @(negedge clk);
      notes.push_back('{2'h2, 0});
      notes.push_back('{2'h3, WD});
      out_good = 1'b1;
      to_rise();
      repeat (100) @(negedge clk);
      notes.push_back('{2'h0, 0});
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      notes.push_back('{2'h2, 0});
      notes.push_back('{2'h3, WD});
      rst_n = 1'b1;
      to_rise();
      cycle(2'h0);
      repeat (10) @(negedge clk);
      check("notes left", 24'(notes.size()), 24'h0);
      conclude();
   end
endmodule // testbench
